// ---- dv/radio_model.sv ----
// radio stand-in: takes bytes, answers carrier sense and acknowledgement
`timescale 1ns/1ps
module radio_model
(
    input  wire       clk,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    output reg        tx_ready,
    input  wire       csma_request,
    output reg        csma_clear,
    output reg        csma_timeout,
    input  wire       ack_wait,
    output reg        ack_received,
    output reg        ack_missing,
    input  wire       busy_mode,
    input  wire       lose_ack,
    input  wire       slow
);
    logic [7:0] got[$];
    reg   [3:0] rc;
    reg   [1:0] cc;
    reg   [1:0] ac;
    initial
    begin
        {tx_ready, csma_clear, csma_timeout, ack_received, ack_missing} = 0;
        {rc, cc, ac} = 0;
    end
    always @(posedge clk)
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
    always @(negedge clk)
    begin
        rc <= rc + 4'h1;
        // slow mode stalls three cycles in four to test byte holding
        tx_ready <= !slow || (rc[1:0] == 2'h0);
        {csma_clear, csma_timeout, ack_received, ack_missing} <= 4'h0;
        cc <= csma_request ? cc + 2'h1 : 2'h0;
        ac <= ack_wait ? ac + 2'h1 : 2'h0;
        if (csma_request && cc == 2'h2)
        begin
            csma_clear <= !busy_mode;
            csma_timeout <= busy_mode;
        end
        if (ack_wait && ac == 2'h2)
        begin
            ack_received <= !lose_ack;
            ack_missing <= lose_ack;
        end
    end
endmodule // radio_model

// ---- dv/tx_fifo_trigger_status_asserts.sv ----
// port assertions for the transmit buffer block
`timescale 1ns/1ps
module tx_fifo_checker
(
    input wire       clk,
    input wire       rst_n,
    input wire       reg_rd,
    input wire       reg_rd_valid,
    input wire       beacon_mode,
    input wire       cap_active,
    input wire [7:0] tx_data,
    input wire       tx_valid,
    input wire       tx_ready,
    input wire       csma_request,
    input wire       csma_clear,
    input wire       csma_timeout,
    input wire       ack_wait,
    input wire       ack_received,
    input wire       ack_missing
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_rd_ans;
        reg_rd |=> reg_rd_valid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
    property p_rd_once;
        !reg_rd |=> !reg_rd_valid;
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("stray answer");
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
    property p_preamble;
        $rose(tx_valid) |-> tx_data == 8'h00;
    endproperty
    a_preamble: assert property (p_preamble) else $error("no preamble");
    property p_fell;
        $fell(tx_valid) |-> $past(tx_ready);
    endproperty
    a_fell: assert property (p_fell) else $error("byte withdrawn");
    property p_cap;
        $rose(csma_request) |-> !beacon_mode || cap_active;
    endproperty
    a_cap: assert property (p_cap) else $error("send outside cap");
    property p_csma;
        csma_request && (csma_clear || csma_timeout) |=> !csma_request;
    endproperty
    a_csma: assert property (p_csma) else $error("sense not ended");
    property p_ack;
        ack_wait && (ack_received || ack_missing) |=> !ack_wait;
    endproperty
    a_ack: assert property (p_ack) else $error("ack wait stuck");
    property p_ack_quiet;
        ack_wait |-> !tx_valid;
    endproperty
    a_ack_quiet: assert property (p_ack_quiet) else $error("send in ack");
endmodule // tx_fifo_checker

bind tx_fifo_trigger_status tx_fifo_checker u_tx_fifo_checker
(
    .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rd_valid(reg_rd_valid),
    .beacon_mode(beacon_mode), .cap_active(cap_active),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .csma_request(csma_request), .csma_clear(csma_clear),
    .csma_timeout(csma_timeout), .ack_wait(ack_wait),
    .ack_received(ack_received), .ack_missing(ack_missing)
);

// ---- dv/tx_fifo_trigger_status_tb.sv ----
// self-checking bench for the transmit buffer block
`timescale 1ns/1ps
`include "tx_fifo_consts.vh"
module tx_fifo_trigger_status_tb;
    reg         clk, rst_n, reg_long, reg_wr, reg_rd, beacon_mode;
    reg         cap_active, beacon_slot, cfp_slot_active, slot_time_short;
    reg         busy_mode, lose_ack, slow;
    reg  [9:0]  reg_addr;
    reg  [7:0]  reg_wdata, rv;
    reg  [2:0]  cfp_slot;
    reg  [31:0] seed;
    wire [7:0]  reg_rdata, tx_data;
    wire        reg_rd_valid, tx_valid, tx_ready, csma_request, csma_clear;
    wire        csma_timeout, ack_wait, ack_received, ack_missing, irq, sec;
    wire [4:0]  hl;
    integer     miscompares, num_checks, irq_seen, i;
    logic [7:0] frame[$];
    logic [9:0] regs[$] = '{10'h01A, 10'h01B, 10'h01C, 10'h01D, 10'h024,
                            10'h031, 10'h032, 10'h020};
    tx_fifo_trigger_status u_tx_fifo_trigger_status
    (
        .clk(clk), .rst_n(rst_n), .reg_long(reg_long), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .beacon_mode(beacon_mode), .cap_active(cap_active),
        .beacon_slot(beacon_slot), .cfp_slot_active(cfp_slot_active),
        .cfp_slot(cfp_slot), .slot_time_short(slot_time_short),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_secure(sec), .tx_header_len(hl), .csma_request(csma_request),
        .csma_clear(csma_clear), .csma_timeout(csma_timeout),
        .ack_wait(ack_wait), .ack_received(ack_received),
        .ack_missing(ack_missing), .irq(irq)
    );
    radio_model u_radio_model
    (
        .clk(clk), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .csma_request(csma_request),
        .csma_clear(csma_clear), .csma_timeout(csma_timeout),
        .ack_wait(ack_wait), .ack_received(ack_received),
        .ack_missing(ack_missing), .busy_mode(busy_mode),
        .lose_ack(lose_ack), .slow(slow)
    );
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk)
        if (irq === 1'b1)
            irq_seen = 1;
    function automatic [7:0] rnd(input integer unused);
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed[7:0];
        end
    endfunction
    task automatic summarize;
        begin
            $display("checks %0d mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task automatic chk(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp)
            begin
                miscompares = miscompares + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task automatic stuck;
        begin
            miscompares = miscompares + 1;
            $display("ERROR %0t: wait ran out", $time);
            summarize;
        end
    endtask
    task automatic wr(input l, input [9:0] a, input [7:0] d);
        begin
            @(negedge clk);
            {reg_long, reg_addr, reg_wdata, reg_wr} = {l, a, d, 1'b1};
            @(negedge clk);
            reg_wr = 1'b0;
        end
    endtask
    task automatic rd(input [9:0] a, output [7:0] d);
        integer n;
        begin
            @(negedge clk);
            {reg_long, reg_addr, reg_rd} = {1'b0, a, 1'b1};
            @(negedge clk);
            reg_rd = 1'b0;
            for (n = 0; n < 4 && reg_rd_valid !== 1'b1; n++)
                @(negedge clk);
            if (reg_rd_valid !== 1'b1)
                stuck;
            d = reg_rdata;
        end
    endtask
    task automatic load(input [9:0] base, input integer len);
        integer k;
        reg [7:0] b;
        begin
            frame.delete();
            wr(1, base, 8'hE2);
            wr(1, base + 10'h001, len[7:0]);
            for (k = 0; k < len; k++)
            begin
                b = rnd(0);
                frame.push_back(b);
                wr(1, base + 10'h002 + k[9:0], b);
            end
        end
    endtask
    task automatic wait_flag(input integer b);
        integer t;
        begin
            rv = 8'h00;
            for (t = 0; t < 400 && rv[b] !== 1'b1; t++)
                rd(`ADDR_INT_FLAGS, rv);
            if (rv[b] !== 1'b1)
                stuck;
        end
    endtask
    // expected on-air stream, once per transmission
    task automatic air(input integer n);
        logic [7:0] e[$];
        reg   [15:0] c;
        integer k, t;
        begin
            c = `CRC_INIT;
            foreach (frame[k])
            begin
                c = c ^ {8'h00, frame[k]};
                repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
            end
            repeat (n) e = {e, 8'h00, 8'h00, 8'h00, 8'h00, `SFD_BYTE,
                            8'(frame.size() + 2), frame, c[7:0], c[15:8]};
            for (t = 0; t < 3000 && u_radio_model.got.size() < e.size(); t++)
                @(negedge clk);
            repeat (20) @(negedge clk);
            chk(8'(u_radio_model.got.size()), 8'(e.size()));
            foreach (e[k])
                if (k < u_radio_model.got.size())
                    chk(u_radio_model.got[k], e[k]);
            u_radio_model.got.delete();
        end
    endtask
    task automatic check_status(input [7:0] exp, input string name);
        begin
            rd(`ADDR_TX_RESULT, rv);
            chk(rv, exp);
            $display("test %s done", name);
        end
    endtask
    initial
    begin
        {rst_n, reg_long, reg_wr, reg_rd, beacon_mode, cap_active} = 0;
        {beacon_slot, cfp_slot_active, slot_time_short, busy_mode} = 0;
        {lose_ack, slow, reg_addr, reg_wdata, cfp_slot} = 0;
        {miscompares, num_checks, irq_seen} = 0;
        seed = 32'hFCD667EB;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        foreach (regs[i])
        begin
            rd(regs[i], rv);
            chk(rv, 8'h00);
        end
        load(10'h000, 5);
        wr(0, `ADDR_NORMAL_CTL, 8'h03);
        wait_flag(0);
        air(1);
        chk({sec, 2'h0, hl}, 8'h82);
        rd(`ADDR_NORMAL_CTL, rv);
        chk(rv, 8'h02);
        chk(8'(irq_seen), 8'h00);
        check_status(8'h00, "normal");
        wr(0, `ADDR_INT_ENABLES, 8'h07);
        lose_ack = 1'b1;
        load(10'h000, 3);
        wr(0, `ADDR_NORMAL_CTL, 8'h05);
        wait_flag(0);
        air(3);
        chk(8'(irq_seen), 8'h01);
        check_status(8'h81, "normal retries");
        {busy_mode, lose_ack} = 2'b10;
        wr(0, `ADDR_NORMAL_CTL, 8'h01);
        wait_flag(0);
        air(0);
        check_status(8'h21, "channel busy");
        {busy_mode, lose_ack, slow, beacon_mode} = 4'b0111;
        {cfp_slot_active, cfp_slot} = {1'b1, 3'h4};
        load(10'h100, 4);
        wr(0, `ADDR_SLOT1_CTL, 8'h6D);
        repeat (30) @(negedge clk);
        chk(8'(u_radio_model.got.size()), 8'h00);
        cfp_slot = 3'h5;
        wait_flag(1);
        air(2);
        rd(`ADDR_SLOT1_CTL, rv);
        chk(rv, 8'h6C);
        check_status(8'h03, "slot one");
        {slot_time_short, cfp_slot} = {1'b1, 3'h2};
        load(10'h180, 2);
        wr(0, `ADDR_SLOT2_CTL, 8'h13);
        wait_flag(2);
        air(0);
        check_status(8'h17, "slot two short");
        {slot_time_short, cfp_slot_active, lose_ack} = 3'b000;
        load(10'h000, 2);
        wr(0, `ADDR_NORMAL_CTL, 8'h05);
        repeat (30) @(negedge clk);
        chk(8'(u_radio_model.got.size()), 8'h00);
        cap_active = 1'b1;
        wait_flag(0);
        air(1);
        check_status(8'h16, "contention phase");
        load(10'h080, 3);
        wr(0, `ADDR_BEACON_CTL, 8'h01);
        repeat (30) @(negedge clk);
        chk(8'(u_radio_model.got.size()), 8'h00);
        beacon_slot = 1'b1;
        @(negedge clk);
        beacon_slot = 1'b0;
        air(1);
        {beacon_mode, slow} = 2'b00;
        load(10'h080, 1);
        wr(0, `ADDR_BEACON_CTL, 8'h03);
        air(1);
        rd(`ADDR_BEACON_CTL, rv);
        chk(rv, 8'h02);
        $display("test beacon done");
        summarize;
    end
endmodule // tx_fifo_trigger_status_tb

// ---- hdl/tx_buffer_ram.v ----
// four 128-byte transmit frame buffers held in flip-flops
`timescale 1ns/1ps
module tx_buffer_ram
(
    input  wire       clk,
    input  wire       wr_en,
    input  wire [8:0] wr_addr,
    input  wire [7:0] wr_data,
    input  wire [8:0] host_addr,
    output wire [7:0] host_data,
    input  wire [8:0] eng_addr,
    output wire [7:0] eng_data
);
    reg [7:0] mem [0:511];

    // contents are frame data only, so no reset is needed
    always @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    assign host_data = mem[host_addr];
    assign eng_data  = mem[eng_addr];
endmodule // tx_buffer_ram

// ---- hdl/tx_fifo_consts.vh ----
// constants for the transmit buffer, trigger and status block
`ifndef TX_FIFO_CONSTS_VH
`define TX_FIFO_CONSTS_VH

`define ADDR_BEACON_CTL   10'h01A
`define ADDR_NORMAL_CTL   10'h01B
`define ADDR_SLOT1_CTL    10'h01C
`define ADDR_SLOT2_CTL    10'h01D
`define ADDR_TX_RESULT    10'h024
`define ADDR_INT_FLAGS    10'h031
`define ADDR_INT_ENABLES  10'h032

`define BUF_NORMAL        2'h0
`define BUF_BEACON        2'h1
`define BUF_SLOT1         2'h2
`define BUF_SLOT2         2'h3

`define OFS_HDR_LEN       7'h00
`define OFS_FRM_LEN       7'h01
`define HDR_LEN_W         5

`define BIT_TRIG          0
`define BIT_SEC           1
`define BIT_ACK           2
`define SLOT_HI           5
`define SLOT_LO           3
`define RETRY_HI          7
`define RETRY_LO          6

`define FLAG_NORMAL       0
`define FLAG_SLOT1        1
`define FLAG_SLOT2        2

`define MAX_RETRY         2'h2
`define PREAMBLE_LEN      8'h04
`define SFD_POS           8'h04
`define PHR_POS           8'h05
`define BODY_START        8'h06
`define BODY_TO_ADDR      8'h04
`define OVERHEAD_LEN      8'h08
`define FCS_LEN           8'h02
`define SFD_BYTE          8'hA7
`define PREAMBLE_BYTE     8'h00
`define CRC_POLY          16'h8408
`define CRC_INIT          16'h0000

`endif

// ---- hdl/tx_fifo_trigger_status.v ----
// transmit buffer control, triggers, sequencer and result registers
`timescale 1ns/1ps
`include "tx_fifo_consts.vh"

// Function
// - beacon mode: normal buffer starts a frame only while the contention phase runs
// - nonbeacon mode: normal buffer sends at once when triggered
// - writing one to normal trigger starts sending; hardware clears it
// - normal completion raises done flag and writes fail status
// - retries used by last normal frame are kept in tx_result
// - channel busy fail set when carrier sense timed out
// - beacon trigger queues beacon; beacon mode sends at superframe start
// - nonbeacon mode sends beacon immediately when triggered
// - host programs slot retry count; hardware writes back retries used
// - slot trigger queues buffer; sent at its programmed slot; self-clears
// - slot completion raises its done flag and writes its fail status
// - slot no-time bit set when too little slot time remained
// - four buffers of 128 bytes, one frame each
// - header length taken as five-bit field
// - hardware adds preamble, delimiter, length header and check sequence
// - missing acknowledgement retransmits, at most three transmissions
module tx_fifo_trigger_status
(
    input  wire       clk,
    input  wire       rst_n,
    input  wire       reg_long,
    input  wire [9:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    output reg        reg_rd_valid,
    input  wire       beacon_mode,
    input  wire       cap_active,
    input  wire       beacon_slot,
    input  wire       cfp_slot_active,
    input  wire [2:0] cfp_slot,
    input  wire       slot_time_short,
    output reg  [7:0] tx_data,
    output reg        tx_valid,
    input  wire       tx_ready,
    output reg        tx_secure,
    output reg  [4:0] tx_header_len,
    output reg        csma_request,
    input  wire       csma_clear,
    input  wire       csma_timeout,
    output reg        ack_wait,
    input  wire       ack_received,
    input  wire       ack_missing,
    output reg        irq
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_LOADH = 3'h1;
    localparam [2:0] ST_LOADL = 3'h2;
    localparam [2:0] ST_CSMA  = 3'h3;
    localparam [2:0] ST_SEND  = 3'h4;
    localparam [2:0] ST_ACKW  = 3'h5;
    localparam [2:0] ST_DONE  = 3'h6;

    reg  [2:0]  state;
    reg  [1:0]  sel;
    reg  [1:0]  beacon_ctl;
    reg  [2:0]  normal_ctl;
    reg  [7:0]  slot_ctl [0:1];
    reg  [2:0]  int_flags;
    reg  [2:0]  int_enables;
    reg         normal_fail;
    reg  [1:0]  normal_retry;
    reg         channel_busy;
    reg  [1:0]  slot_fail;
    reg  [1:0]  slot_no_time;
    reg  [6:0]  frame_len;
    reg  [7:0]  pos;
    reg  [15:0] crc;
    reg  [1:0]  retries;
    reg         ack_req;
    reg         fail;
    reg         fail_busy;
    reg         fail_time;
    integer     k;

    wire [7:0] host_data;
    wire [7:0] eng_data;
    wire [8:0] eng_addr;
    wire [7:0] pos_m4;
    wire [7:0] total;
    wire [7:0] tx_result;
    wire       buf_wr;
    wire       beacon_go;
    wire       slot1_go;
    wire       slot2_go;
    wire       normal_go;
    wire       slot_sel;
    wire [1:0] retry_limit;
    wire       byte_slot;

    function [15:0] crc_step;
        input [15:0] c;
        input [7:0]  d;
        integer      i;
        reg   [15:0] r;
        begin
            r = c;
            for (i = 0; i < 8; i = i + 1)
                r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
            crc_step = r;
        end
    endfunction

    function slot_due;
        input [7:0] ctl;
        begin
            slot_due = ctl[`BIT_TRIG] && beacon_mode && cfp_slot_active
                       && (cfp_slot == ctl[`SLOT_HI:`SLOT_LO]);
        end
    endfunction

    assign buf_wr    = reg_wr && reg_long && !reg_addr[9];
    assign pos_m4    = pos - `BODY_TO_ADDR;
    assign eng_addr  = (state == ST_LOADH) ? {sel, `OFS_HDR_LEN} :
                       (state == ST_LOADL) ? {sel, `OFS_FRM_LEN} :
                       {sel, pos_m4[6:0]};
    assign total     = {1'b0, frame_len} + `OVERHEAD_LEN;
    assign tx_result = {normal_retry, channel_busy, slot_no_time,
                        slot_fail, normal_fail};
    assign beacon_go = beacon_ctl[`BIT_TRIG]
                       && (!beacon_mode || beacon_slot);
    assign slot1_go  = slot_due(slot_ctl[0]);
    assign slot2_go  = slot_due(slot_ctl[1]);
    assign normal_go = normal_ctl[`BIT_TRIG]
                       && (!beacon_mode || cap_active);
    assign slot_sel  = sel[1];
    // the programmed slot retry count cannot exceed the fixed ceiling
    assign retry_limit = !slot_sel ? `MAX_RETRY :
        (slot_ctl[sel[0]][`RETRY_HI:`RETRY_LO] > `MAX_RETRY) ? `MAX_RETRY :
        slot_ctl[sel[0]][`RETRY_HI:`RETRY_LO];
    assign byte_slot = !tx_valid || tx_ready;

    tx_buffer_ram u_ram
    (
        .clk       (clk),
        .wr_en     (buf_wr),
        .wr_addr   (reg_addr[8:0]),
        .wr_data   (reg_wdata),
        .host_addr (reg_addr[8:0]),
        .host_data (host_data),
        .eng_addr  (eng_addr),
        .eng_data  (eng_data)
    );

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state         <= ST_IDLE;
            sel           <= `BUF_NORMAL;
            beacon_ctl    <= 2'h0;
            normal_ctl    <= 3'h0;
            slot_ctl[0]   <= 8'h00;
            slot_ctl[1]   <= 8'h00;
            int_flags     <= 3'h0;
            int_enables   <= 3'h0;
            normal_fail   <= 1'b0;
            normal_retry  <= 2'h0;
            channel_busy  <= 1'b0;
            slot_fail     <= 2'h0;
            slot_no_time  <= 2'h0;
            frame_len     <= 7'h00;
            pos           <= 8'h00;
            crc           <= `CRC_INIT;
            retries       <= 2'h0;
            ack_req       <= 1'b0;
            fail          <= 1'b0;
            fail_busy     <= 1'b0;
            fail_time     <= 1'b0;
            reg_rdata     <= 8'h00;
            reg_rd_valid  <= 1'b0;
            tx_data       <= 8'h00;
            tx_valid      <= 1'b0;
            tx_secure     <= 1'b0;
            tx_header_len <= 5'h00;
            csma_request  <= 1'b0;
            ack_wait      <= 1'b0;
            irq           <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd;
            // read-to-clear happens first so a same-cycle completion wins
            if (reg_rd)
            begin
                reg_rdata <= 8'h00;
                if (reg_long)
                begin
                    if (!reg_addr[9])
                        reg_rdata <= host_data;
                end
                else
                    case (reg_addr)
                    `ADDR_BEACON_CTL:  reg_rdata <= {6'h00, beacon_ctl};
                    `ADDR_NORMAL_CTL:  reg_rdata <= {5'h00, normal_ctl};
                    `ADDR_SLOT1_CTL:   reg_rdata <= slot_ctl[0];
                    `ADDR_SLOT2_CTL:   reg_rdata <= slot_ctl[1];
                    `ADDR_TX_RESULT:   reg_rdata <= tx_result;
                    `ADDR_INT_FLAGS:
                    begin
                        reg_rdata <= {5'h00, int_flags};
                        int_flags <= 3'h0;
                    end
                    `ADDR_INT_ENABLES: reg_rdata <= {5'h00, int_enables};
                    default:           reg_rdata <= 8'h00;
                    endcase
            end

            case (state)
            ST_IDLE:
            begin
                retries   <= 2'h0;
                fail      <= 1'b0;
                fail_busy <= 1'b0;
                fail_time <= 1'b0;
                pos       <= 8'h00;
                crc       <= `CRC_INIT;
                // beacon first, then slots, then the contention buffer
                if (beacon_go)
                begin
                    sel        <= `BUF_BEACON;
                    ack_req    <= 1'b0;
                    tx_secure  <= beacon_ctl[`BIT_SEC];
                    beacon_ctl[`BIT_TRIG] <= 1'b0;
                    state      <= ST_LOADH;
                end
                else if (slot1_go || slot2_go)
                begin
                    sel     <= slot1_go ? `BUF_SLOT1 : `BUF_SLOT2;
                    for (k = 0; k < 2; k = k + 1)
                        if ((k == 0) == slot1_go)
                        begin
                            ack_req   <= slot_ctl[k][`BIT_ACK];
                            tx_secure <= slot_ctl[k][`BIT_SEC];
                            slot_ctl[k][`BIT_TRIG] <= 1'b0;
                        end
                    state   <= ST_LOADH;
                end
                else if (normal_go)
                begin
                    sel        <= `BUF_NORMAL;
                    ack_req    <= normal_ctl[`BIT_ACK];
                    tx_secure  <= normal_ctl[`BIT_SEC];
                    normal_ctl[`BIT_TRIG] <= 1'b0;
                    state      <= ST_LOADH;
                end
            end
            ST_LOADH:
            begin
                tx_header_len <= eng_data[`HDR_LEN_W-1:0];
                state         <= ST_LOADL;
            end
            ST_LOADL:
            begin
                frame_len <= eng_data[6:0];
                if (slot_sel && slot_time_short)
                begin
                    fail      <= 1'b1;
                    fail_time <= 1'b1;
                    state     <= ST_DONE;
                end
                else if (sel == `BUF_NORMAL)
                    state <= ST_CSMA;
                else
                    state <= ST_SEND;
            end
            ST_CSMA:
            begin
                csma_request <= 1'b1;
                if (csma_clear)
                begin
                    csma_request <= 1'b0;
                    state        <= ST_SEND;
                end
                else if (csma_timeout)
                begin
                    csma_request <= 1'b0;
                    fail         <= 1'b1;
                    fail_busy    <= 1'b1;
                    state        <= ST_DONE;
                end
            end
            ST_SEND:
            begin
                if (byte_slot && pos != total)
                begin
                    tx_valid <= 1'b1;
                    pos      <= pos + 8'h01;
                    // framing bytes around the stored frame
                    if (pos < `PREAMBLE_LEN)
                        tx_data <= `PREAMBLE_BYTE;
                    else if (pos == `SFD_POS)
                        tx_data <= `SFD_BYTE;
                    else if (pos == `PHR_POS)
                        tx_data <= {1'b0, frame_len} + `FCS_LEN;
                    else if (pos < total - `FCS_LEN)
                    begin
                        tx_data <= eng_data;
                        crc     <= crc_step(crc, eng_data);
                    end
                    else if (pos == total - `FCS_LEN)
                        tx_data <= crc[7:0];
                    else
                        tx_data <= crc[15:8];
                end
                else if (byte_slot)
                begin
                    tx_valid <= 1'b0;
                    if (ack_req)
                        state <= ST_ACKW;
                    else
                        state <= ST_DONE;
                end
            end
            ST_ACKW:
            begin
                ack_wait <= 1'b1;
                if (ack_received)
                begin
                    ack_wait <= 1'b0;
                    state    <= ST_DONE;
                end
                else if (ack_missing)
                begin
                    ack_wait <= 1'b0;
                    pos      <= 8'h00;
                    crc      <= `CRC_INIT;
                    if (retries < retry_limit)
                    begin
                        retries <= retries + 2'h1;
                        state   <= slot_sel ? ST_SEND : ST_CSMA;
                    end
                    else
                    begin
                        fail  <= 1'b1;
                        state <= ST_DONE;
                    end
                end
            end
            ST_DONE:
            begin
                state <= ST_IDLE;
                if (sel == `BUF_NORMAL)
                begin
                    int_flags[`FLAG_NORMAL] <= 1'b1;
                    normal_fail  <= fail;
                    normal_retry <= retries;
                    channel_busy <= fail_busy;
                end
                else if (slot_sel)
                begin
                    int_flags[`FLAG_SLOT1 + sel[0]] <= 1'b1;
                    slot_fail[sel[0]]    <= fail;
                    slot_no_time[sel[0]] <= fail_time;
                    slot_ctl[sel[0]][`RETRY_HI:`RETRY_LO] <= retries;
                    channel_busy <= fail_busy;
                end
            end
            default: state <= ST_IDLE;
            endcase

            // host writes last: a trigger write beats the self-clear
            if (reg_wr && !reg_long)
                case (reg_addr)
                `ADDR_BEACON_CTL:
                begin
                    beacon_ctl[`BIT_SEC] <= reg_wdata[`BIT_SEC];
                    if (reg_wdata[`BIT_TRIG])
                        beacon_ctl[`BIT_TRIG] <= 1'b1;
                end
                `ADDR_NORMAL_CTL:
                begin
                    normal_ctl[2:1] <= reg_wdata[2:1];
                    if (reg_wdata[`BIT_TRIG])
                        normal_ctl[`BIT_TRIG] <= 1'b1;
                end
                `ADDR_SLOT1_CTL, `ADDR_SLOT2_CTL:
                begin
                    slot_ctl[reg_addr[0]][7:1] <= reg_wdata[7:1];
                    if (reg_wdata[`BIT_TRIG])
                        slot_ctl[reg_addr[0]][`BIT_TRIG] <= 1'b1;
                end
                `ADDR_INT_ENABLES: int_enables <= reg_wdata[2:0];
                default: ;
                endcase

            irq <= |(int_flags & int_enables);
        end
    end
endmodule // tx_fifo_trigger_status
